// File: rtl/rf_pkg.sv
// Purpose: shared constants for the banked core register file
// Assumes: 32-bit data, five-bit mode field
// Notes: mode codes, bank slots, status word fields, bus map
package rf_pkg;
    localparam logic [4:0] MODE_USR = 5'h10;
    localparam logic [4:0] MODE_FIQ = 5'h11;
    localparam logic [4:0] MODE_IRQ = 5'h12;
    localparam logic [4:0] MODE_SVC = 5'h13;
    localparam logic [4:0] MODE_ABT = 5'h17;
    localparam logic [4:0] MODE_UND = 5'h1B;
    localparam logic [4:0] MODE_SYS = 5'h1F;
    localparam int T_BIT = 5;
    localparam int MODE_MSB = 4;
    localparam int NUM_PHYS = 30;
    localparam logic [4:0] FIQ_BASE = 5'h0F;
    localparam logic [4:0] IRQ_BASE = 5'h16;
    localparam logic [4:0] SVC_BASE = 5'h18;
    localparam logic [4:0] ABT_BASE = 5'h1A;
    localparam logic [4:0] UND_BASE = 5'h1C;
    localparam logic [3:0] IDX_HI = 4'h8;
    localparam logic [3:0] IDX_SP = 4'hD;
    localparam logic [3:0] IDX_LR = 4'hE;
    localparam logic [3:0] IDX_PC = 4'hF;
    localparam logic [2:0] SLOT_NONE = 3'h7;
    localparam logic [31:0] CURRENT_STATUS_WORD_RST = {27'h0, MODE_SVC};
    localparam logic [31:0] RESET_VEC = 32'h0000_0000;
    localparam logic [31:0] MASK_WIDE = 32'hFFFF_FFFC;
    localparam logic [31:0] MASK_COMPACT = 32'hFFFF_FFFE;
    localparam logic [31:0] STEP_WIDE = 32'h0000_0004;
    localparam logic [31:0] STEP_COMPACT = 32'h0000_0002;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] OFF_PC = 8'h08;
    localparam logic [7:0] OFF_FAULT = 8'h0C;
    localparam int CTRL_BIG = 0;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    function automatic logic mode_legal(input logic [4:0] m);
        return m inside {MODE_USR, MODE_FIQ, MODE_IRQ, MODE_SVC, MODE_ABT, MODE_UND, MODE_SYS};
    endfunction

    function automatic logic [2:0] saved_status_word_slot(input logic [4:0] m);
        return (m == MODE_FIQ) ? 3'h0 : (m == MODE_IRQ) ? 3'h1 : (m == MODE_SVC) ? 3'h2 :
            (m == MODE_ABT) ? 3'h3 : (m == MODE_UND) ? 3'h4 : SLOT_NONE;
    endfunction
endpackage

// File: rtl/lane_steer.sv
// Purpose: byte lane steering for loads and stores
// Assumes: little lane n carries bits 8n+7..8n
// Notes: purely combinational, the top registers its outputs
`timescale 1ns/100ps
module lane_steer (
    input wire logic [1:0] i_addr,
    input wire logic [1:0] i_size,
    input wire logic i_big,
    input wire logic [31:0] i_wdata,
    input wire logic [31:0] i_rdata,
    output logic [31:0] o_lanes,
    output logic [3:0] o_be,
    output logic [31:0] o_load,
    output logic o_misalign
);
    wire logic [1:0] byte_lane = i_big ? ~i_addr : i_addr;
    wire logic half_lane = i_big ? ~i_addr[1] : i_addr[1];
    wire logic is_byte = (i_size == rf_pkg::SZ_BYTE);
    wire logic is_half = (i_size == rf_pkg::SZ_HALF);
    wire logic [31:0] byte_sh = i_rdata >> {byte_lane, 3'h0};
    wire logic [31:0] half_sh = i_rdata >> {half_lane, 4'h0};

    assign o_misalign = (is_half & i_addr[0]) | (!is_byte & !is_half & (|i_addr));
    assign o_lanes = is_byte ? {4{i_wdata[7:0]}} : is_half ? {2{i_wdata[15:0]}} : i_wdata;
    assign o_be = is_byte ? 4'(4'h1 << byte_lane) : is_half ? (half_lane ? 4'hC : 4'h3) : 4'hF;
    assign o_load = is_byte ? {24'h0, byte_sh[7:0]} : is_half ? {16'h0, half_sh[15:0]} : i_rdata;
endmodule // lane_steer

// File: rtl/banked_core_register_file.sv
// Purpose: banked register file, status words and instruction state control
// Assumes: core decode drives one-cycle strobes; AXI4-Lite for control
// Notes: reads answer one cycle after the index is presented
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
module banked_core_register_file #(
    parameter int AW = 8
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic [3:0] i_rd_a_idx,
    input wire logic [3:0] i_rd_b_idx,
    input wire logic i_hi_access,
    output logic [31:0] o_rd_a_data,
    output logic [31:0] o_rd_b_data,
    input wire logic i_wr_en,
    input wire logic [3:0] i_wr_idx,
    input wire logic [31:0] i_wr_data,
    input wire logic i_branch_with_link_op,
    input wire logic i_state_exchange_branch,
    input wire logic [31:0] i_xchg_operand,
    input wire logic i_pc_load,
    input wire logic [31:0] i_pc_target,
    input wire logic i_pc_advance,
    input wire logic i_exc_take,
    input wire logic [4:0] i_exc_mode,
    input wire logic [31:0] i_exc_vector,
    input wire logic i_exc_return,
    input wire logic i_status_wr,
    input wire logic [31:0] i_status_data,
    input wire logic i_saved_wr,
    input wire logic [31:0] i_saved_data,
    input wire logic [31:0] i_fetch_word,
    input wire logic [1:0] i_mem_addr,
    input wire logic [1:0] i_mem_size,
    input wire logic [31:0] i_mem_wdata,
    input wire logic [31:0] i_mem_rdata,
    output logic [31:0] o_instr,
    output logic [31:0] o_mem_lanes,
    output logic [3:0] o_mem_be,
    output logic [31:0] o_load_data,
    output logic o_misalign,
    output logic o_state_flag_output,
    output logic [4:0] o_mode,
    output logic o_privileged,
    output logic [31:0] o_pc,
    output logic [31:0] o_current_status_word,
    output logic [31:0] o_saved_status_word,
    output logic o_locked,
    input wire logic [AW-1:0] i_awaddr,
    input wire logic i_awvalid,
    output logic o_awready,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_wstrb,
    input wire logic i_wvalid,
    output logic o_wready,
    output logic [1:0] o_bresp,
    output logic o_bvalid,
    input wire logic i_bready,
    input wire logic [AW-1:0] i_araddr,
    input wire logic i_arvalid,
    output logic o_arready,
    output logic [31:0] o_rdata,
    output logic [1:0] o_rresp,
    output logic o_rvalid,
    input wire logic i_rready
);
    logic [31:0] gpr_q [rf_pkg::NUM_PHYS];
    logic [31:0] saved_status_word_q [5];
    logic [31:0] current_status_word_q, current_status_word_d, pc_q, pc_d;
    logic lock_q, lock_d, priv_q, big_q;
    logic [AW-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic wbe_q;

    function automatic logic [4:0] phys(input logic [3:0] idx, input logic [4:0] m);
        logic [4:0] base;
        base = (m == rf_pkg::MODE_IRQ) ? rf_pkg::IRQ_BASE : (m == rf_pkg::MODE_SVC) ?
            rf_pkg::SVC_BASE : (m == rf_pkg::MODE_ABT) ? rf_pkg::ABT_BASE :
            (m == rf_pkg::MODE_UND) ? rf_pkg::UND_BASE : 5'h00;
        if (m == rf_pkg::MODE_FIQ && idx >= rf_pkg::IDX_HI && idx != rf_pkg::IDX_PC) begin
            return rf_pkg::FIQ_BASE + 5'(idx - rf_pkg::IDX_HI);
        end
        if ((idx == rf_pkg::IDX_SP || idx == rf_pkg::IDX_LR) && base != 5'h00) begin
            return base + 5'(idx - rf_pkg::IDX_SP);
        end
        return {1'b0, idx};
    endfunction

    // current mode and state decode
    wire logic [4:0] mode = current_status_word_q[rf_pkg::MODE_MSB:0];
    wire logic compact = current_status_word_q[rf_pkg::T_BIT];
    wire logic [2:0] cur_slot = rf_pkg::saved_status_word_slot(mode);
    wire logic [2:0] exc_slot = rf_pkg::saved_status_word_slot(i_exc_mode);
    wire logic [31:0] saved_status_word_cur = (cur_slot == rf_pkg::SLOT_NONE) ? current_status_word_q : saved_status_word_q[cur_slot];
    wire logic [4:0] cur_lr_phys = phys(rf_pkg::IDX_LR, mode);
    wire logic [4:0] exc_lr_phys = phys(rf_pkg::IDX_LR, i_exc_mode);
    wire logic [4:0] rd_a_phys = phys(i_rd_a_idx, mode);
    wire logic [4:0] rd_b_phys = phys(i_rd_b_idx, mode);
    wire logic [4:0] wr_phys = phys(i_wr_idx, mode);

    // compact state hides 8..12 unless a special operation asks
    wire logic a_ok = !compact || i_rd_a_idx < rf_pkg::IDX_HI || i_rd_a_idx >= rf_pkg::IDX_SP ||
        i_hi_access;
    wire logic b_ok = !compact || i_rd_b_idx < rf_pkg::IDX_HI || i_rd_b_idx >= rf_pkg::IDX_SP ||
        i_hi_access;
    wire logic w_ok = !compact || i_wr_idx < rf_pkg::IDX_HI || i_wr_idx >= rf_pkg::IDX_SP ||
        i_hi_access;
    wire logic [31:0] rd_a_val = (i_rd_a_idx == rf_pkg::IDX_PC) ? pc_q :
        a_ok ? gpr_q[rd_a_phys] : 32'h0000_0000;
    wire logic [31:0] rd_b_val = (i_rd_b_idx == rf_pkg::IDX_PC) ? pc_q :
        b_ok ? gpr_q[rd_b_phys] : 32'h0000_0000;

    // single write port: exception link, then branch-with-link, then plain write
    wire logic link_wr = i_exc_take || i_branch_with_link_op;
    wire logic plain_wr = i_wr_en && i_wr_idx != rf_pkg::IDX_PC && w_ok;
    wire logic gpr_we = !lock_q && (link_wr || plain_wr);
    wire logic [4:0] gpr_wa = i_exc_take ? exc_lr_phys :
        i_branch_with_link_op ? cur_lr_phys : wr_phys;
    wire logic [31:0] gpr_wd = link_wr ? pc_q : i_wr_data;
    wire logic saved_status_word_exc_we = !lock_q && i_exc_take && exc_slot != rf_pkg::SLOT_NONE;
    wire logic saved_status_word_sw_we = !lock_q && i_saved_wr && cur_slot != rf_pkg::SLOT_NONE;

    // compact fetch picks a halfword by pc bit 1, lane order follows endianness
    wire logic half_sel = big_q ? ~pc_q[1] : pc_q[1];
    wire logic [31:0] fetch_sh = i_fetch_word >> {half_sel, 4'h0};
    wire logic [31:0] instr_d = compact ? {16'h0000, fetch_sh[15:0]} : i_fetch_word;

    wire logic [31:0] lanes_d, load_d;
    wire logic [3:0] be_d;
    wire logic mis_d;

    lane_steer u_steer (
        .i_addr(i_mem_addr),
        .i_size(i_mem_size),
        .i_big(big_q),
        .i_wdata(i_mem_wdata),
        .i_rdata(i_mem_rdata),
        .o_lanes(lanes_d),
        .o_be(be_d),
        .o_load(load_d),
        .o_misalign(mis_d)
    );

    always_comb begin
        logic [31:0] sw;
        sw = i_status_data;
        sw[rf_pkg::T_BIT] = current_status_word_q[rf_pkg::T_BIT];
        current_status_word_d = current_status_word_q;
        pc_d = pc_q;
        lock_d = lock_q;
        if (lock_q) begin
            lock_d = 1'b1;
        end else if (i_exc_take) begin
            current_status_word_d[rf_pkg::MODE_MSB:0] = i_exc_mode;
            current_status_word_d[rf_pkg::T_BIT] = 1'b0;
            pc_d = i_exc_vector & rf_pkg::MASK_WIDE;
        end else if (i_exc_return) begin
            current_status_word_d = saved_status_word_cur;
            pc_d = i_pc_target & (saved_status_word_cur[rf_pkg::T_BIT] ? rf_pkg::MASK_COMPACT :
                rf_pkg::MASK_WIDE);
        end else begin
            if (i_state_exchange_branch) begin
                current_status_word_d[rf_pkg::T_BIT] = i_xchg_operand[0];
                pc_d = i_xchg_operand & (i_xchg_operand[0] ? rf_pkg::MASK_COMPACT :
                    rf_pkg::MASK_WIDE);
            end else if (i_pc_load) begin
                pc_d = i_pc_target & (compact ? rf_pkg::MASK_COMPACT : rf_pkg::MASK_WIDE);
            end else if (i_pc_advance) begin
                pc_d = pc_q + (compact ? rf_pkg::STEP_COMPACT : rf_pkg::STEP_WIDE);
            end
            if (i_status_wr && !i_state_exchange_branch) begin
                current_status_word_d = sw;
            end
        end
        if (!rf_pkg::mode_legal(current_status_word_d[rf_pkg::MODE_MSB:0])) begin
            lock_d = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            current_status_word_q <= rf_pkg::CURRENT_STATUS_WORD_RST;
            pc_q <= rf_pkg::RESET_VEC;
            lock_q <= 1'b0;
            priv_q <= 1'b1;
        end else begin
            current_status_word_q <= current_status_word_d;
            pc_q <= pc_d;
            lock_q <= lock_d;
            priv_q <= current_status_word_d[rf_pkg::MODE_MSB:0] != rf_pkg::MODE_USR;
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            for (int k = 0; k < rf_pkg::NUM_PHYS; k++) begin
                gpr_q[k] <= 32'h0000_0000;
            end
            for (int k = 0; k < 5; k++) begin
                saved_status_word_q[k] <= 32'h0000_0000;
            end
        end else begin
            if (gpr_we) begin
                gpr_q[gpr_wa] <= gpr_wd;
            end
            if (saved_status_word_exc_we) begin
                saved_status_word_q[exc_slot] <= current_status_word_q;
            end else if (saved_status_word_sw_we) begin
                saved_status_word_q[cur_slot] <= i_saved_data;
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_rd_a_data <= 32'h0000_0000;
            o_rd_b_data <= 32'h0000_0000;
            o_instr <= 32'h0000_0000;
            o_mem_lanes <= 32'h0000_0000;
            o_mem_be <= 4'h0;
            o_load_data <= 32'h0000_0000;
            o_misalign <= 1'b0;
            o_saved_status_word <= 32'h0000_0000;
        end else begin
            o_rd_a_data <= rd_a_val;
            o_rd_b_data <= rd_b_val;
            o_instr <= instr_d;
            o_mem_lanes <= lanes_d;
            o_mem_be <= be_d;
            o_load_data <= load_d;
            o_misalign <= mis_d;
            o_saved_status_word <= saved_status_word_cur;
        end
    end

    assign o_state_flag_output = current_status_word_q[rf_pkg::T_BIT];
    assign o_mode = current_status_word_q[rf_pkg::MODE_MSB:0];
    assign o_privileged = priv_q;
    assign o_pc = pc_q;
    assign o_current_status_word = current_status_word_q;
    assign o_locked = lock_q;

    // control bus slave
    wire logic aw_hs = i_awvalid && o_awready;
    wire logic w_hs = i_wvalid && o_wready;
    wire logic do_wr = !o_awready && !o_wready && !o_bvalid;
    wire logic wr_ctrl = (awaddr_q == AW'(rf_pkg::OFF_CTRL));
    wire logic wr_known = wr_ctrl || awaddr_q == AW'(rf_pkg::OFF_STATUS) ||
        awaddr_q == AW'(rf_pkg::OFF_PC) || awaddr_q == AW'(rf_pkg::OFF_FAULT);
    wire logic rd_known = i_araddr == AW'(rf_pkg::OFF_CTRL) ||
        i_araddr == AW'(rf_pkg::OFF_STATUS) || i_araddr == AW'(rf_pkg::OFF_PC) ||
        i_araddr == AW'(rf_pkg::OFF_FAULT);
    wire logic [31:0] rd_mux = (i_araddr == AW'(rf_pkg::OFF_CTRL)) ? {31'h0, big_q} :
        (i_araddr == AW'(rf_pkg::OFF_STATUS)) ? current_status_word_q :
        (i_araddr == AW'(rf_pkg::OFF_PC)) ? pc_q :
        (i_araddr == AW'(rf_pkg::OFF_FAULT)) ? {31'h0, lock_q} : 32'h0000_0000;

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_awready <= 1'b1;
            o_wready <= 1'b1;
            o_bvalid <= 1'b0;
            o_bresp <= rf_pkg::RESP_OKAY;
            awaddr_q <= '0;
            wdata_q <= 32'h0000_0000;
            wbe_q <= 1'b0;
            big_q <= 1'b0;
        end else begin
            if (aw_hs) begin
                o_awready <= 1'b0;
                awaddr_q <= i_awaddr;
            end
            if (w_hs) begin
                o_wready <= 1'b0;
                wdata_q <= i_wdata;
                wbe_q <= i_wstrb[0];
            end
            if (do_wr) begin
                o_bvalid <= 1'b1;
                o_bresp <= wr_known ? rf_pkg::RESP_OKAY : rf_pkg::RESP_SLVERR;
                if (wr_ctrl && wbe_q) begin
                    big_q <= wdata_q[rf_pkg::CTRL_BIG];
                end
            end
            if (o_bvalid && i_bready) begin
                o_bvalid <= 1'b0;
                o_awready <= 1'b1;
                o_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
            o_arready <= 1'b1;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= rf_pkg::RESP_OKAY;
        end else if (i_arvalid && o_arready) begin
            o_arready <= 1'b0;
            o_rvalid <= 1'b1;
            o_rdata <= rd_mux;
            o_rresp <= rd_known ? rf_pkg::RESP_OKAY : rf_pkg::RESP_SLVERR;
        end else if (o_rvalid && i_rready) begin
            o_rvalid <= 1'b0;
            o_arready <= 1'b1;
        end
    end

    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);

    sequence exc_req;
        !lock_q && i_exc_take && rf_pkg::mode_legal(i_exc_mode);
    endsequence

    sequence exc_done(logic [4:0] m, logic [31:0] v);
        !compact && mode == m && pc_q == (v & rf_pkg::MASK_WIDE);
    endsequence

    chk_exc_entry: assert property (exc_req |=> exc_done($past(i_exc_mode), $past(i_exc_vector)))
        else $error("exception entry state wrong");
    chk_exc_link: assert property (exc_req |=> gpr_q[cur_lr_phys] == $past(pc_q))
        else $error("link not saved on exception");
    chk_exc_saved: assert property (exc_req ##0 (rf_pkg::saved_status_word_slot(i_exc_mode) !=
        rf_pkg::SLOT_NONE) |=> saved_status_word_cur == $past(current_status_word_q))
        else $error("status not saved on exception");
    chk_xchg_state: assert property (!lock_q && i_state_exchange_branch && !i_exc_take &&
        !i_exc_return |=> compact == $past(i_xchg_operand[0]) && mode == $past(mode))
        else $error("exchange branch state wrong");
    chk_ret_state: assert property (!lock_q && i_exc_return && !i_exc_take |=>
        compact == $past(saved_status_word_cur[rf_pkg::T_BIT]))
        else $error("return state not restored");
    chk_pc_low: assert property (pc_q[0] == 1'b0 && (compact || pc_q[1] == 1'b0))
        else $error("pc low bits not clear");
    chk_lock_hold: assert property (lock_q |=> lock_q [*3])
        else $error("lock released without reset");
    chk_bad_mode: assert property (!lock_q && i_status_wr && !i_exc_take && !i_exc_return &&
        !i_state_exchange_branch && !rf_pkg::mode_legal(i_status_data[4:0]) |=> lock_q)
        else $error("illegal mode not locked");
    chk_fiq_bank: assert property (mode == rf_pkg::MODE_FIQ && i_rd_a_idx == rf_pkg::IDX_HI |->
        rd_a_phys == rf_pkg::FIQ_BASE)
        else $error("fast bank not selected");
    chk_bl_link: assert property (!lock_q && i_branch_with_link_op && !i_exc_take |=>
        gpr_q[$past(cur_lr_phys)] == $past(pc_q))
        else $error("link not written on branch");
    chk_state_out: assert property (##1 $changed(o_state_flag_output) |->
        $past(i_state_exchange_branch) || $past(i_exc_take) || $past(i_exc_return))
        else $error("state flag moved without cause");
endmodule // banked_core_register_file

// File: testbench/core_memory_model.sv
// Purpose: memory beside the core, answers instruction fetches
// Assumes: word-aligned fetch address from the core
// Notes: each word is built from its own address so halves differ
`timescale 1ns/100ps
module core_memory_model (
    input wire logic [31:0] i_addr,
    output logic [31:0] o_word
);
    assign o_word = {i_addr[15:0] ^ 16'hA5A5, i_addr[15:0]};
endmodule // core_memory_model

// File: testbench/banked_core_register_file_bench.sv
// Purpose: self-checking bench for the banked core register file
// Assumes: 40 MHz clock, one-edge answers on the core ports
// Notes: rows cover lane steering; hand tests cover state, banking, lock
`timescale 1ns/100ps
module banked_core_register_file_bench;
    typedef struct packed {
        logic big; logic [3:0] x; logic [3:0] be; logic [31:0] ld; logic mis;
    } row_t;
    localparam row_t ROWS [8] = '{
        '{1'b0, 4'h1, 4'h2, 32'h0000_0022, 1'b0}, '{1'b0, 4'h6, 4'hC, 32'h0000_4433, 1'b0},
        '{1'b0, 4'h8, 4'hF, 32'h4433_2211, 1'b0}, '{1'b0, 4'hA, 4'h0, 32'h0000_0000, 1'b1},
        '{1'b1, 4'h0, 4'h8, 32'h0000_0044, 1'b0}, '{1'b1, 4'h4, 4'hC, 32'h0000_4433, 1'b0},
        '{1'b1, 4'h3, 4'h1, 32'h0000_0011, 1'b0}, '{1'b0, 4'h0, 4'h1, 32'h0000_0011, 1'b0}};
    logic i_ref_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [7:0] s = 8'h00;
    logic [3:0] x = 4'h0;
    logic [31:0] v = 32'h0000_0000;
    logic [4:0] m = 5'h00;
    logic hi = 1'b0;
    logic [31:0] rdb, lanes;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, tflag, priv, locked, mis;
    logic [1:0] bresp, rresp, resp;
    logic [31:0] rda, instr, ld, pc, csw, ssw, rdata, fetch, rd;
    logic [4:0] mode;
    logic [3:0] be;
    int bad_count = 0;
    int compares = 0;

    always #12.5 i_ref_clk = ~i_ref_clk;

    banked_core_register_file #(.AW(8)) dut (
        .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_rd_a_idx(x), .i_rd_b_idx(x),
        .i_hi_access(hi), .o_rd_a_data(rda), .o_rd_b_data(rdb), .i_wr_en(s[0]),
        .i_wr_idx(x), .i_wr_data(v), .i_branch_with_link_op(s[1]),
        .i_state_exchange_branch(s[2]), .i_xchg_operand(v), .i_pc_load(s[3]),
        .i_pc_target(v), .i_pc_advance(s[4]), .i_exc_take(s[5]), .i_exc_mode(m),
        .i_exc_vector(v), .i_exc_return(s[6]), .i_status_wr(s[7]), .i_status_data(v),
        .i_saved_wr(1'b0), .i_saved_data(v), .i_fetch_word(fetch), .i_mem_addr(x[1:0]),
        .i_mem_size(x[3:2]), .i_mem_wdata(v), .i_mem_rdata(v), .o_instr(instr),
        .o_mem_lanes(lanes), .o_mem_be(be), .o_load_data(ld), .o_misalign(mis),
        .o_state_flag_output(tflag), .o_mode(mode), .o_privileged(priv), .o_pc(pc),
        .o_current_status_word(csw), .o_saved_status_word(ssw), .o_locked(locked),
        .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
        .i_wstrb(4'hF), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
        .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
        .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
        .i_rready(rready));

    core_memory_model mem (.i_addr({pc[31:2], 2'h0}), .o_word(fetch));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one strobe cycle on the core ports, outputs settled on return
    task automatic op(input logic [7:0] w, input logic [3:0] i, input logic [31:0] d,
        input logic [4:0] md);
        @(posedge i_ref_clk);
        s <= w;
        x <= i;
        v <= d;
        m <= md;
        @(posedge i_ref_clk);
        s <= 8'h00;
        @(negedge i_ref_clk);
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge i_ref_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
        bready <= 1'b0;
    endtask

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge i_ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge i_ref_clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic results;
        $display("comparisons %0d, mismatches %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    initial begin
        repeat (4000) @(posedge i_ref_clk);
        bad_count++;
        results();
    end

    initial begin
        repeat (10) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        @(negedge i_ref_clk);
        check(mode, rf_pkg::MODE_SVC);
        check(tflag, 1'b0);
        check(pc, rf_pkg::RESET_VEC);
        check(csw, rf_pkg::CURRENT_STATUS_WORD_RST);
        check(priv, 1'b1);
        $display("reset test done");
        foreach (ROWS[i]) begin
            axi_wr(rf_pkg::OFF_CTRL, {31'h0, ROWS[i].big}, resp);
            op(8'h00, ROWS[i].x, 32'h4433_2211, 5'h00);
            check(mis, ROWS[i].mis);
            if (!ROWS[i].mis) begin
                check(be, ROWS[i].be);
                check(ld, ROWS[i].ld);
            end
        end
        check(lanes, 32'h1111_1111);
        $display("lane rows done");
        op(8'h01, 4'h3, 32'h0000_0033, 5'h00);
        op(8'h01, rf_pkg::IDX_SP, 32'h0000_1313, 5'h00);
        op(8'h01, 4'h8, 32'h0000_0088, 5'h00);
        op(8'h08, 4'h3, 32'h0000_0203, 5'h00);
        check(pc, 32'h0000_0200);
        op(8'h04, 4'h3, 32'h0000_0101, 5'h00);
        check(tflag, 1'b1);
        check(pc, 32'h0000_0100);
        check(mode, rf_pkg::MODE_SVC);
        check(rda, 32'h0000_0033);
        op(8'h00, 4'h8, 32'h0000_0000, 5'h00);
        check(rda, 32'h0000_0000);
        @(posedge i_ref_clk);
        hi <= 1'b1;
        op(8'h00, 4'h8, 32'h0000_0000, 5'h00);
        check(rda, 32'h0000_0088);
        check(rdb, 32'h0000_0088);
        @(posedge i_ref_clk);
        hi <= 1'b0;
        op(8'h10, 4'h0, 32'h0000_0000, 5'h00);
        check(pc, 32'h0000_0102);
        check(instr[15:0], 16'h0100);
        op(8'h00, 4'h0, 32'h0000_0000, 5'h00);
        check(instr[15:0], 16'hA4A5);
        op(8'h20, 4'h0, 32'h0000_0018, rf_pkg::MODE_IRQ);
        check(tflag, 1'b0);
        check(pc, 32'h0000_0018);
        check(mode, rf_pkg::MODE_IRQ);
        op(8'h00, rf_pkg::IDX_SP, 32'h0000_0000, 5'h00);
        check(rda, 32'h0000_0000);
        check(ssw, 32'h0000_0033);
        op(8'h00, rf_pkg::IDX_LR, 32'h0000_0000, 5'h00);
        check(rda, 32'h0000_0102);
        op(8'h40, rf_pkg::IDX_SP, 32'h0000_0102, 5'h00);
        check(tflag, 1'b1);
        check(mode, rf_pkg::MODE_SVC);
        op(8'h00, rf_pkg::IDX_SP, 32'h0000_0000, 5'h00);
        check(rda, 32'h0000_1313);
        op(8'h04, 4'h0, 32'h0000_0300, 5'h00);
        check(tflag, 1'b0);
        check(pc, 32'h0000_0300);
        op(8'h02, 4'h0, 32'h0000_0000, 5'h00);
        op(8'h00, rf_pkg::IDX_LR, 32'h0000_0000, 5'h00);
        check(rda, 32'h0000_0300);
        $display("state and bank tests done");
        op(8'h80, 4'h0, 32'h0000_0000, 5'h00);
        check(locked, 1'b1);
        op(8'h08, 4'h0, 32'h0000_0400, 5'h00);
        check(pc, 32'h0000_0300);
        axi_rd(rf_pkg::OFF_FAULT, rd, resp);
        check(rd[0], 1'b1);
        axi_rd(rf_pkg::OFF_PC, rd, resp);
        check(rd, 32'h0000_0300);
        axi_rd(8'h40, rd, resp);
        check(resp, rf_pkg::RESP_SLVERR);
        check(rd, 32'h0000_0000);
        $display("lock and bus tests done");
        results();
    end
endmodule // banked_core_register_file_bench
